// file: verilog/clock_power_mode_unit_defines.vh
`ifndef CLOCK_POWER_MODE_UNIT_DEFINES_VH
`define CLOCK_POWER_MODE_UNIT_DEFINES_VH

// register byte offsets
`define OFS_SRC_CTRL 8'h00
`define OFS_MASTER_DIV 8'h04
`define OFS_CLK_MASK 8'h08
`define OFS_PWR_CTRL 8'h0c
`define OFS_STATUS 8'h10
`define OFS_PRESCALE 8'h14

// source control fields
`define SRC_SEL_LSB 0
`define SRC_SEL_MSB 1
`define SRC_PLL_EN 2
`define SRC_SPEEDUP 3
`define SRC_USB_EXT 4
`define SRC_TIM01_EXT 5
`define SRC_TIM23_EXT 6

// power control fields
`define PWR_IDLE_REQ 0
`define PWR_SLEEP_REQ 1

// status fields
`define ST_SRC_LSB 0
`define ST_PLL_LOCK 2
`define ST_PLL_ON 3
`define ST_MODE_LSB 4
`define ST_SWITCHING 6

// master source encodings
`define SRC_OSC 2'h0
`define SRC_PLL 2'h1
`define SRC_RTC 2'h2

// power mode encodings
`define MODE_RUN 2'h0
`define MODE_IDLE 2'h1
`define MODE_SLEEP 2'h2

// derived clock indices and count
`define NUM_CLK 7
`define CLK_CPU 0
`define CLK_AHB 1
`define CLK_APB 2
`define CLK_FLASH 3
`define CLK_EMI 4
`define CLK_UART 5
`define CLK_USB 6

// reset values
`define RST_SRC_CTRL 7'h00
`define RST_MASTER_DIV 10'h000
`define RST_CLK_MASK 7'h7f
`define RST_PRESCALE 28'h0000000

// widths
`define MDIV_W 10
`define PRE_W 4

// source rates: pll fastest rate in MHz, rtc rate in Hz
`define PLL_MAX_MHZ 96
`define RTC_FREQ_HZ 32768

`endif

// file: verilog/clock_power_mode_unit.v
// Function
// - master clock from one of oscillator, pll, rtc; switching is glitch free
// - oscillator after reset; pll selectable only once locked, up to 96 MHz
// - firmware may go back to oscillator any time and power pll down
// - sleep entry forces the pll off whatever its enable was
// - 32.768 kHz rtc may be chosen as master source at any time
// - cpu, ahb, apb, flash, emi, uart, usb clocks each divided and gated
// - dynamic master divider up to 1024 for cpu, ahb, apb, emi, flash
// - run mode: all clocks run except those masked off by firmware
// - any reset enters run mode
// - speed-up option: cpu clock undivided while an interrupt is serviced
// - idle request stops cpu and flash clocks at once
// - idle keeps peripheral clocks per the mask held just before idle
// - idle exits to run on reset, interrupt or wake-up input
// - sleep stops all clocks but rtc and timer ticks taken from external pins, disables oscillator pins
// - sleep exit happens only on reset or, with wake-up input, on an rtc clock tick
// - debug active: no clock is ever gated, even in idle or sleep
// - usb and timers may take dedicated external clock pins instead
`timescale 1ns/10ps
`include "clock_power_mode_unit_defines.vh"

module clock_power_mode_unit (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire osc_tick,
    input wire pll_tick,
    input wire rtc_tick,
    input wire pll_lock,
    input wire irq_active,
    input wire irq_pending,
    input wire wake_in,
    input wire debug_active,
    input wire usb_ext_tick,
    input wire tim01_ext_tick,
    input wire tim23_ext_tick,
    output reg master_en_ff,
    output reg [6:0] clk_en_ff,
    output reg tim01_tick_ff,
    output reg tim23_tick_ff,
    output reg pll_power_ff,
    output reg osc_pins_off_ff,
    output reg [1:0] mode_ff
);

    reg [6:0] src_ctrl_ff;
    reg [`MDIV_W-1:0] mdiv_ff;
    reg [6:0] mask_ff;
    reg [6:0] idle_mask_ff;
    reg [27:0] prescale_ff;
    reg [1:0] cur_src_ff;
    reg [`MDIV_W-1:0] mdiv_cnt_ff;
    reg wr_pend_ff;
    reg [7:0] wr_addr_ff;

    wire [1:0] req_src;
    wire switching;
    wire old_tick;
    wire master_tick;
    wire div_tick;
    wire cpu_fast;
    wire bus_take;
    wire [7:0] ofs;
    wire [6:0] gate_ok;
    wire [6:0] pre_tick;
    reg [31:0] rd_val;
    reg [1:0] nxt_mode;
    reg [6:0] nxt_src_ctrl;

    assign req_src = src_ctrl_ff[`SRC_SEL_MSB:`SRC_SEL_LSB];
    assign switching = (req_src != cur_src_ff);
    assign bus_take = hsel & hready & htrans[1];
    assign ofs = haddr[7:0];

    // the old source must finish its tick before the mux moves
    assign old_tick = (cur_src_ff == `SRC_PLL) ? (pll_tick | ~pll_power_ff) :
                      (cur_src_ff == `SRC_RTC) ? rtc_tick : osc_tick;

    // sleep stops the master clock unless debug keeps everything alive
    assign master_tick = ~switching & ~((mode_ff == `MODE_SLEEP) & ~debug_active) &
                         ((cur_src_ff == `SRC_PLL) ? pll_tick :
                          (cur_src_ff == `SRC_RTC) ? rtc_tick : osc_tick);

    assign div_tick = master_tick & (mdiv_cnt_ff == {`MDIV_W{1'b0}});
    assign cpu_fast = src_ctrl_ff[`SRC_SPEEDUP] & irq_active;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mdiv_cnt_ff <= {`MDIV_W{1'b0}};
        end else if (master_tick) begin
            // divisor change takes effect at the next wrap, no short pulse
            if (mdiv_cnt_ff == {`MDIV_W{1'b0}})
                mdiv_cnt_ff <= mdiv_ff;
            else
                mdiv_cnt_ff <= mdiv_cnt_ff - {{(`MDIV_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_src_ff <= `SRC_OSC;
        end else if ((mode_ff == `MODE_SLEEP) & ~debug_active) begin
            cur_src_ff <= `SRC_OSC;
        end else if (switching & old_tick) begin
            cur_src_ff <= req_src;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `NUM_CLK; i = i + 1) begin : g_clk
            reg [`PRE_W-1:0] pre_cnt_ff;
            wire base_tick;
            // uart and usb sit after the master clock, not the master divider
            assign base_tick = (i < `CLK_UART) ? div_tick : master_tick;
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    pre_cnt_ff <= {`PRE_W{1'b0}};
                end else if (base_tick) begin
                    if (pre_cnt_ff == {`PRE_W{1'b0}})
                        pre_cnt_ff <= prescale_ff[i*`PRE_W +: `PRE_W];
                    else
                        pre_cnt_ff <= pre_cnt_ff - {{(`PRE_W-1){1'b0}}, 1'b1};
                end
            end
            assign pre_tick[i] = base_tick & (pre_cnt_ff == {`PRE_W{1'b0}});
            assign gate_ok[i] = debug_active |
                                ((mode_ff == `MODE_RUN) & mask_ff[i]) |
                                ((mode_ff == `MODE_IDLE) & idle_mask_ff[i] &
                                 (i != `CLK_CPU) & (i != `CLK_FLASH));
        end
    endgenerate

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_en_ff <= 7'h00;
            master_en_ff <= 1'b0;
            tim01_tick_ff <= 1'b0;
            tim23_tick_ff <= 1'b0;
        end else begin
            master_en_ff <= master_tick;
            clk_en_ff <= pre_tick & gate_ok;
            if (cpu_fast)
                clk_en_ff[`CLK_CPU] <= master_tick & gate_ok[`CLK_CPU];
            if (src_ctrl_ff[`SRC_USB_EXT])
                clk_en_ff[`CLK_USB] <= usb_ext_tick & gate_ok[`CLK_USB];
            // timers run from the apb clock unless an external pin is chosen
            tim01_tick_ff <= src_ctrl_ff[`SRC_TIM01_EXT] ? tim01_ext_tick :
                             (pre_tick[`CLK_APB] & gate_ok[`CLK_APB]);
            tim23_tick_ff <= src_ctrl_ff[`SRC_TIM23_EXT] ? tim23_ext_tick :
                             (pre_tick[`CLK_APB] & gate_ok[`CLK_APB]);
        end
    end

    // power mode sequencing
    always @* begin
        nxt_mode = mode_ff;
        case (mode_ff)
            `MODE_RUN: begin
                if (wr_pend_ff & (wr_addr_ff == `OFS_PWR_CTRL)) begin
                    if (hwdata[`PWR_SLEEP_REQ])
                        nxt_mode = `MODE_SLEEP;
                    else if (hwdata[`PWR_IDLE_REQ])
                        nxt_mode = `MODE_IDLE;
                end
            end
            `MODE_IDLE: begin
                if (irq_pending | wake_in)
                    nxt_mode = `MODE_RUN;
            end
            `MODE_SLEEP: begin
                // wake only registers on an rtc tick: no rtc, no exit
                if (rtc_tick & wake_in)
                    nxt_mode = `MODE_RUN;
            end
            default: nxt_mode = `MODE_RUN;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_ff <= `MODE_RUN;
            idle_mask_ff <= `RST_CLK_MASK;
        end else begin
            mode_ff <= nxt_mode;
            if ((mode_ff == `MODE_RUN) & (nxt_mode == `MODE_IDLE))
                idle_mask_ff <= mask_ff;
        end
    end

    // source control: firmware writes, hardware overrides
    always @* begin
        nxt_src_ctrl = src_ctrl_ff;
        if (wr_pend_ff & (wr_addr_ff == `OFS_SRC_CTRL)) begin
            nxt_src_ctrl = hwdata[6:0];
            // pll selection refused until it is powered and locked
            if ((hwdata[1:0] == `SRC_PLL) & ~(pll_lock & hwdata[`SRC_PLL_EN]))
                nxt_src_ctrl[1:0] = src_ctrl_ff[1:0];
            if (hwdata[1:0] == 2'h3)
                nxt_src_ctrl[1:0] = src_ctrl_ff[1:0];
            // powering pll down while selected drops back to oscillator
            if (~hwdata[`SRC_PLL_EN] & (nxt_src_ctrl[1:0] == `SRC_PLL))
                nxt_src_ctrl[1:0] = `SRC_OSC;
        end
        if ((mode_ff != `MODE_SLEEP) & (nxt_mode == `MODE_SLEEP)) begin
            nxt_src_ctrl[`SRC_PLL_EN] = 1'b0;
            nxt_src_ctrl[1:0] = `SRC_OSC;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_ctrl_ff <= `RST_SRC_CTRL;
            mdiv_ff <= `RST_MASTER_DIV;
            mask_ff <= `RST_CLK_MASK;
            prescale_ff <= `RST_PRESCALE;
            pll_power_ff <= 1'b0;
            osc_pins_off_ff <= 1'b0;
        end else begin
            src_ctrl_ff <= nxt_src_ctrl;
            if (wr_pend_ff & (wr_addr_ff == `OFS_MASTER_DIV))
                mdiv_ff <= hwdata[`MDIV_W-1:0];
            if (wr_pend_ff & (wr_addr_ff == `OFS_CLK_MASK))
                mask_ff <= hwdata[6:0];
            if (wr_pend_ff & (wr_addr_ff == `OFS_PRESCALE))
                prescale_ff <= hwdata[27:0];
            pll_power_ff <= nxt_src_ctrl[`SRC_PLL_EN] & (nxt_mode != `MODE_SLEEP);
            osc_pins_off_ff <= (nxt_mode == `MODE_SLEEP) & ~debug_active;
        end
    end

    // ahb-lite slave: zero wait, read data registered in the address phase
    always @* begin
        rd_val = 32'h00000000;
        case (ofs)
            `OFS_SRC_CTRL: rd_val = {25'h0000000, src_ctrl_ff};
            `OFS_MASTER_DIV: rd_val = {22'h000000, mdiv_ff};
            `OFS_CLK_MASK: rd_val = {25'h0000000, mask_ff};
            `OFS_PWR_CTRL: rd_val = 32'h00000000;
            `OFS_STATUS: rd_val = {25'h0000000, switching, mode_ff, pll_power_ff, pll_lock, cur_src_ff};
            `OFS_PRESCALE: rd_val = {4'h0, prescale_ff};
            default: rd_val = 32'h00000000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_ff <= bus_take & hwrite;
            if (bus_take)
                wr_addr_ff <= ofs;
            if (bus_take & ~hwrite)
                hrdata <= rd_val;
        end
    end

endmodule // clock_power_mode_unit

// file: dv/clock_sources.sv
`timescale 1ns/10ps
module clock_sources #(parameter int OSC_P = 3, parameter int RTC_P = 16, parameter int LOCK_T = 20) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pll_power_ff,
    input wire logic rtc_run,
    output logic osc_tick,
    output logic pll_tick,
    output logic rtc_tick,
    output logic pll_lock,
    output logic ext_tick
);
    int n;
    int lk;
    // lock is lost one cycle after power drops, as a real loop would
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            n <= 0;
            lk <= 0;
        end else begin
            n <= n + 1;
            lk <= pll_power_ff ? lk + 1 : 0;
        end
    end
    assign osc_tick = (n % OSC_P) == 0;
    assign rtc_tick = rtc_run && (n % RTC_P) == 0;
    assign pll_lock = lk >= LOCK_T;
    assign pll_tick = pll_lock;
    assign ext_tick = (n % 5) == 2;
endmodule // clock_sources

// file: dv/clock_power_mode_unit_monitor.sv
`timescale 1ns/10ps
module clock_power_mode_unit_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic osc_tick,
    input wire logic pll_tick,
    input wire logic rtc_tick,
    input wire logic irq_pending,
    input wire logic wake_in,
    input wire logic debug_active,
    input wire logic master_en_ff,
    input wire logic [6:0] clk_en_ff,
    input wire logic pll_power_ff,
    input wire logic osc_pins_off_ff,
    input wire logic [1:0] mode_ff
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_reset_run: assert property ($rose(hresetn) |-> mode_ff == 2'h0)
        else $error("mode not run after reset");
    chk_sleep_pll_off: assert property (mode_ff == 2'h2 && $past(mode_ff) == 2'h2 |-> !pll_power_ff)
        else $error("pll powered in sleep");
    chk_sleep_gated: assert property ((mode_ff == 2'h2 && !debug_active)[*3] |-> clk_en_ff == 7'h00)
        else $error("clock pulse in sleep");
    chk_sleep_pins: assert property ((mode_ff == 2'h2 && !debug_active)[*2] |-> osc_pins_off_ff)
        else $error("oscillator pins left on in sleep");
    chk_debug_pins: assert property (debug_active[*2] |-> !osc_pins_off_ff)
        else $error("oscillator pins off under debug");
    chk_idle_cpu_off: assert property ((mode_ff == 2'h1 && !debug_active)[*3] |-> !clk_en_ff[0] && !clk_en_ff[3])
        else $error("cpu or flash clock in idle");
    chk_idle_exit: assert property (mode_ff == 2'h1 && (irq_pending || wake_in) |=> mode_ff == 2'h0)
        else $error("idle not left on event");
    chk_sleep_rtc: assert property (mode_ff == 2'h2 && !rtc_tick |=> mode_ff == 2'h2)
        else $error("sleep left without rtc tick");
    chk_master_src: assert property (master_en_ff |-> $past(osc_tick || pll_tick || rtc_tick))
        else $error("master tick without source tick");
    cover property (mode_ff == 2'h1 ##1 mode_ff == 2'h0);
    cover property (mode_ff == 2'h2 && debug_active);
    cover property (mode_ff == 2'h2 ##1 mode_ff == 2'h0);
endmodule // clock_power_mode_unit_checker
bind clock_power_mode_unit clock_power_mode_unit_checker mon (.hclk, .hresetn, .osc_tick, .pll_tick, .rtc_tick,
    .irq_pending, .wake_in, .debug_active, .master_en_ff, .clk_en_ff, .pll_power_ff, .osc_pins_off_ff, .mode_ff);

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_active = 0, irq_pending = 0, wake_in = 0;
    logic debug_active = 0, rtc_run = 1;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, osc_tick, pll_tick, rtc_tick, pll_lock, ext_tick, master_en_ff, tim01_tick_ff;
    wire tim23_tick_ff, pll_power_ff, osc_pins_off_ff;
    wire [6:0] clk_en_ff;
    wire [1:0] mode_ff;
    wire [7:0] ev = {tim01_tick_ff, clk_en_ff};
    int n_mismatch = 0, check_count = 0;
    always #20 hclk = ~hclk;
    clock_power_mode_unit DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .osc_tick, .pll_tick, .rtc_tick, .pll_lock, .irq_active,
        .irq_pending, .wake_in, .debug_active, .usb_ext_tick(ext_tick), .tim01_ext_tick(ext_tick),
        .tim23_ext_tick(ext_tick), .master_en_ff, .clk_en_ff, .tim01_tick_ff, .tim23_tick_ff, .pll_power_ff,
        .osc_pins_off_ff, .mode_ff);
    clock_sources src (.hclk, .hresetn, .pll_power_ff, .rtc_run, .osc_tick, .pll_tick, .rtc_tick, .pll_lock,
        .ext_tick);
    task step(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task ck(input logic [31:0] e, input logic [31:0] s, input string nm);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(0, a, 0);
        ck(e, hrdata, nm);
    endtask
    // osc ticks every 3 cycles, so windows of 240 give exact counts
    task cnt(input int b, input int n, input int e, input string nm);
        int c;
        c = 0;
        step(12);
        repeat (n) begin
            @(posedge hclk);
            c += ev[b];
        end
        ck(e, c, nm);
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        step(40000);
        n_mismatch++;
        results;
    end
    initial begin
        step(8);
        hresetn <= 1;
        @(posedge hclk);
        ck(0, mode_ff, "mode");
        ck(0, hresp, "hresp");
        ck(1, hreadyout, "hreadyout");
        rd(8'h00, 0, "src");
        rd(8'h04, 0, "div");
        rd(8'h08, 32'h7f, "mask");
        rd(8'h14, 0, "pre");
        rd(8'h0c, 0, "pwr");
        rd(8'h20, 0, "unmapped");
        rd(8'h10, 0, "status");
        bus(1, 8'h00, 5);
        rd(8'h00, 4, "sel unlocked");
        step(30);
        bus(1, 8'h00, 5);
        step(12);
        rd(8'h10, 32'h0d, "status pll");
        cnt(5, 240, 240, "uart pll");
        bus(1, 8'h00, 0);
        step(12);
        rd(8'h10, 0, "status osc");
        bus(1, 8'h00, 2);
        step(12);
        rd(8'h10, 2, "status rtc");
        cnt(5, 240, 15, "uart rtc");
        bus(1, 8'h00, 0);
        // the move back to the oscillator waits for the next slow tick
        step(20);
        $display("source tests done");
        bus(1, 8'h04, 3);
        cnt(0, 240, 20, "cpu div4");
        cnt(5, 240, 80, "uart");
        bus(1, 8'h14, 32'h100);
        cnt(2, 240, 10, "apb pre2");
        bus(1, 8'h00, 8);
        irq_active <= 1;
        cnt(0, 240, 80, "cpu speedup");
        irq_active <= 0;
        cnt(0, 240, 20, "cpu restored");
        bus(1, 8'h04, 32'h3ff);
        cnt(0, 3072, 1, "cpu div1024");
        bus(1, 8'h04, 0);
        // new ratio only loads at the wrap of the old count of 1024 master ticks
        step(3080);
        bus(1, 8'h08, 32'h7e);
        cnt(0, 240, 0, "cpu masked");
        cnt(1, 240, 80, "ahb run");
        $display("divider tests done");
        bus(1, 8'h08, 32'h5f);
        bus(1, 8'h0c, 1);
        step(2);
        ck(1, mode_ff, "idle");
        cnt(0, 240, 0, "cpu idle");
        cnt(3, 240, 0, "flash idle");
        cnt(1, 240, 80, "ahb idle");
        cnt(5, 240, 0, "uart idle");
        irq_pending <= 1;
        step(2);
        ck(0, mode_ff, "irq exit");
        irq_pending <= 0;
        bus(1, 8'h0c, 1);
        wake_in <= 1;
        step(2);
        ck(0, mode_ff, "wake exit");
        wake_in <= 0;
        $display("idle tests done");
        bus(1, 8'h00, 4);
        step(30);
        bus(1, 8'h00, 5);
        step(12);
        rtc_run <= 0;
        bus(1, 8'h0c, 3);
        step(2);
        ck(2, mode_ff, "sleep");
        ck(0, pll_power_ff, "pll sleep");
        cnt(1, 240, 0, "ahb sleep");
        wake_in <= 1;
        step(40);
        ck(2, mode_ff, "no rtc");
        rtc_run <= 1;
        step(40);
        ck(0, mode_ff, "sleep exit");
        wake_in <= 0;
        rd(8'h00, 0, "src after sleep");
        rd(8'h10, 0, "status after sleep");
        debug_active <= 1;
        bus(1, 8'h0c, 2);
        step(2);
        ck(2, mode_ff, "debug sleep");
        cnt(1, 240, 80, "ahb debug");
        wake_in <= 1;
        step(40);
        wake_in <= 0;
        debug_active <= 0;
        $display("sleep tests done");
        bus(1, 8'h00, 32'h20);
        cnt(7, 240, 48, "tim01 ext");
        $display("external clock test done");
        results;
    end
endmodule // tb
